// ### rtl/ubc_pkg.sv
// Types shared by the break unit and its bench
package break_unit_pkg;

    // Operand size of a monitored bus cycle
    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_WORD,
        SIZE_LONG
    } op_size_type;

    // One monitored processor or DMA bus cycle
    typedef struct packed {
        logic        valid;
        logic        dma;
        logic        fetch;
        logic        write;
        op_size_type size;
        logic [31:0] addr;
    } bus_cycle_type;

    // Low byte of the cycle-select register
    typedef struct packed {
        logic [1:0] master;
        logic [1:0] access;
        logic [1:0] direction;
        logic [1:0] size;
    } cycle_select_type;

endpackage

// ### rtl/ubc_regs.svh
// Register indices, field positions and reset values of the break unit
`ifndef BREAK_UNIT_REGS_SVH
`define BREAK_UNIT_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_ADDR_HIGH   28'h5FFFF90
`define IDX_ADDR_LOW    28'h5FFFF92
`define IDX_MASK_HIGH   28'h5FFFF94
`define IDX_MASK_LOW    28'h5FFFF96
`define IDX_CYCLE_SEL   28'h5FFFF98
`define IDX_EVT_STATUS  28'h5FFFF9A
`define IDX_EVT_MASK    28'h5FFFF9C

// Reset values
`define RST_HALF        16'h0000
`define RST_SELECT      8'h00
`define RST_EVENT       2'h0

// Event bit positions in status and mask
`define EVT_BREAK       0
`define EVT_FETCH       1

// AXI response codes
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### rtl/user_break_unit.sv
// User break unit: bus-cycle comparator with AXI4-Lite registers
//
// Behaviour
// R1 - A bus-cycle address can be a break condition against a 32-bit target.
// R2 - Break can be qualified by master: processor, DMA engine, or either.
// R3 - Break can be qualified by instruction fetch, data access, or both.
// R4 - Break can be qualified by read or write and by operand size.
// R5 - A matching monitored cycle raises a break request to the core.
// R6 - A fetch break takes effect before the fetched instruction executes.
// R7 - Five 16-bit registers: address high/low, mask high/low, cycle select.
// R8 - Reset clears all five break registers to zero.
// R9 - Byte, halfword and word register accesses are accepted.
// R10 - Decode uses only index bits 27 to 24 and 8 to 0.
// R11 - A mask bit of one drops that address bit from the comparison.
// R12 - Select field 00 gives no break; 01 first, 10 second, 11 both. The size field instead uses 00 for any size, 01 byte, 10 word, 11 long.
// R13 - Address high holds bits 31 to 16, address low bits 15 to 0.
// R14 - Standby keeps register contents; only reset reinitialises them.
// R15 - Break only when every enabled qualifier matches in one cycle.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ubc_regs.svh"

module user_break_unit
    import break_unit_pkg::*;
(
    input  wire logic          I_CLK,
    input  wire logic          I_RST,
    input  wire bus_cycle_type I_BUS,
    input  wire logic [31:0]   I_AWADDR,
    input  wire logic          I_AWVALID,
    output logic               O_AWREADY,
    input  wire logic [31:0]   I_WDATA,
    input  wire logic [3:0]    I_WSTRB,
    input  wire logic          I_WVALID,
    output logic               O_WREADY,
    output logic [1:0]         O_BRESP,
    output logic               O_BVALID,
    input  wire logic          I_BREADY,
    input  wire logic [31:0]   I_ARADDR,
    input  wire logic          I_ARVALID,
    output logic               O_ARREADY,
    output logic [31:0]        O_RDATA,
    output logic [1:0]         O_RRESP,
    output logic               O_RVALID,
    input  wire logic          I_RREADY,
    output logic               O_IRQ,
    output logic               O_BREAK_FETCH
);

    // Break registers
    logic [15:0]      addr_high;
    logic [15:0]      addr_low;
    logic [15:0]      mask_high;
    logic [15:0]      mask_low;
    cycle_select_type select;
    logic [1:0]       evt_status;
    logic [1:0]       evt_mask;

    // Write channel holding state
    logic             aw_held;
    logic [27:0]      aw_idx;
    logic             w_held;
    logic [15:0]      w_data;
    logic [1:0]       w_strb;
    logic             do_write;
    logic             write_ok;

    // Comparator terms
    logic [31:0]      target;
    logic [31:0]      ignore;
    logic             addr_ok;
    logic             master_ok;
    logic             access_ok;
    logic             dir_ok;
    logic             size_ok;
    logic             hit;
    logic [1:0]       clear_bits;

    // Index match on the decoded bits only
    function automatic logic idx_is(input logic [27:0] idx,
                                    input logic [27:0] reg_idx);
        idx_is = (idx[27:24] == reg_idx[27:24])
               && (idx[8:0] == reg_idx[8:0]); // R10
    endfunction

    // Byte-lane merge into a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] data,
                                          input logic [1:0]  strb);
        merge = old;
        if (strb[0]) begin
            merge[7:0] = data[7:0]; // R9
        end
        if (strb[1]) begin
            merge[15:8] = data[15:8]; // R9
        end
    endfunction

    // Mapped-index check
    function automatic logic mapped(input logic [27:0] idx);
        mapped = idx_is(idx, `IDX_ADDR_HIGH)
              || idx_is(idx, `IDX_ADDR_LOW)
              || idx_is(idx, `IDX_MASK_HIGH)
              || idx_is(idx, `IDX_MASK_LOW)
              || idx_is(idx, `IDX_CYCLE_SEL)
              || idx_is(idx, `IDX_EVT_STATUS)
              || idx_is(idx, `IDX_EVT_MASK);
    endfunction

    // Write address and data are taken independently
    assign O_AWREADY = !aw_held && !O_BVALID;
    assign O_WREADY  = !w_held && !O_BVALID;
    assign do_write  = aw_held && w_held && !O_BVALID;
    assign write_ok  = do_write && mapped(aw_idx);

    // Write address capture
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            aw_held <= 1'b0;
            aw_idx  <= 28'h0000000;
        end else if (I_AWVALID && O_AWREADY) begin
            aw_held <= 1'b1;
            aw_idx  <= I_AWADDR[29:2];
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // Write data capture, low halfword only
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            w_held <= 1'b0;
            w_data <= 16'h0000;
            w_strb <= 2'h0;
        end else if (I_WVALID && O_WREADY) begin
            w_held <= 1'b1;
            w_data <= I_WDATA[15:0];
            w_strb <= I_WSTRB[1:0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Write response after both halves
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_BVALID <= 1'b0;
            O_BRESP  <= `RESP_OKAY;
        end else if (do_write) begin
            O_BVALID <= 1'b1;
            O_BRESP  <= write_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    // Break registers; standby has no path here
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            addr_high <= `RST_HALF; // R8
            addr_low  <= `RST_HALF;
            mask_high <= `RST_HALF;
            mask_low  <= `RST_HALF;
            select    <= `RST_SELECT;
            evt_mask  <= `RST_EVENT;
        end else if (write_ok) begin // R14
            if (idx_is(aw_idx, `IDX_ADDR_HIGH)) begin
                addr_high <= merge(addr_high, w_data, w_strb); // R7
            end
            if (idx_is(aw_idx, `IDX_ADDR_LOW)) begin
                addr_low <= merge(addr_low, w_data, w_strb); // R7
            end
            if (idx_is(aw_idx, `IDX_MASK_HIGH)) begin
                mask_high <= merge(mask_high, w_data, w_strb); // R7
            end
            if (idx_is(aw_idx, `IDX_MASK_LOW)) begin
                mask_low <= merge(mask_low, w_data, w_strb); // R7
            end
            if (idx_is(aw_idx, `IDX_CYCLE_SEL) && w_strb[0]) begin
                select <= w_data[7:0]; // R7
            end
            if (idx_is(aw_idx, `IDX_EVT_MASK) && w_strb[0]) begin
                evt_mask <= w_data[1:0];
            end
        end
    end

    // Address compare with per-bit exclusion
    assign target  = {addr_high, addr_low}; // R13
    assign ignore  = {mask_high, mask_low};
    assign addr_ok = ((I_BUS.addr ^ target) & ~ignore)
                     == 32'h00000000; // R11 R1

    // Qualifiers: bit 0 first option, bit 1 second option
    assign master_ok = I_BUS.dma ? select.master[1]
                                 : select.master[0]; // R2 R12
    assign access_ok = I_BUS.fetch ? select.access[0]
                                   : select.access[1]; // R3 R12
    assign dir_ok    = I_BUS.write ? select.direction[1]
                                   : select.direction[0]; // R4 R12
    // Size 00 leaves size out; 01 byte, 10 word, 11 long
    assign size_ok   = (select.size == 2'h0)
                    || (select.size
                        == 2'(I_BUS.size + 2'h1)); // R4

    // All enabled qualifiers in the same cycle
    assign hit = I_BUS.valid && addr_ok && master_ok
              && access_ok && dir_ok && size_ok; // R15

    // Write-one-to-clear bits
    assign clear_bits = (write_ok && idx_is(aw_idx, `IDX_EVT_STATUS)
                        && w_strb[0]) ? w_data[1:0] : 2'h0;

    // Sticky events; a new hit wins over the clear
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            evt_status <= `RST_EVENT;
        end else begin
            evt_status[`EVT_BREAK] <= hit
                || (evt_status[`EVT_BREAK]
                    && !clear_bits[`EVT_BREAK]); // R5
            evt_status[`EVT_FETCH] <= (hit && I_BUS.fetch && !I_BUS.dma)
                || (evt_status[`EVT_FETCH]
                    && !clear_bits[`EVT_FETCH]); // R6
        end
    end

    // Break request toward the core
    assign O_IRQ = |(evt_status & evt_mask); // R5

    // Fetch break flag, raised the cycle after the fetch
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_BREAK_FETCH <= 1'b0;
        end else if (hit) begin
            O_BREAK_FETCH <= I_BUS.fetch && !I_BUS.dma; // R6
        end
    end

    // Read channel, answer one cycle after the address
    assign O_ARREADY = !O_RVALID;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RVALID <= 1'b0;
            O_RDATA  <= 32'h00000000;
            O_RRESP  <= `RESP_OKAY;
        end else if (I_ARVALID && O_ARREADY) begin
            O_RVALID <= 1'b1;
            O_RRESP  <= mapped(I_ARADDR[29:2]) ? `RESP_OKAY
                                               : `RESP_SLVERR;
            O_RDATA  <= 32'h00000000;
            if (idx_is(I_ARADDR[29:2], `IDX_ADDR_HIGH)) begin
                O_RDATA[15:0] <= addr_high;
            end
            if (idx_is(I_ARADDR[29:2], `IDX_ADDR_LOW)) begin
                O_RDATA[15:0] <= addr_low;
            end
            if (idx_is(I_ARADDR[29:2], `IDX_MASK_HIGH)) begin
                O_RDATA[15:0] <= mask_high;
            end
            if (idx_is(I_ARADDR[29:2], `IDX_MASK_LOW)) begin
                O_RDATA[15:0] <= mask_low;
            end
            if (idx_is(I_ARADDR[29:2], `IDX_CYCLE_SEL)) begin
                O_RDATA[7:0] <= select;
            end
            if (idx_is(I_ARADDR[29:2], `IDX_EVT_STATUS)) begin
                O_RDATA[1:0] <= evt_status;
            end
            if (idx_is(I_ARADDR[29:2], `IDX_EVT_MASK)) begin
                O_RDATA[1:0] <= evt_mask;
            end
        end else if (I_RREADY) begin
            O_RVALID <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);

    property p_hit_sets_status;
        hit |=> evt_status[`EVT_BREAK] [*1];
    endproperty
    a_hit_sets_status: assert property (p_hit_sets_status) // R5
        else $error("break hit did not set status");

    property p_no_master;
        (select.master == 2'h0) |-> !hit;
    endproperty
    a_no_master: assert property (p_no_master) // R12
        else $error("break with master field 00");

    property p_no_access;
        (select.access == 2'h0) |-> !hit;
    endproperty
    a_no_access: assert property (p_no_access) // R3
        else $error("break with access field 00");

    property p_direction;
        (select.direction == 2'h1 && I_BUS.write) |-> !hit;
    endproperty
    a_direction: assert property (p_direction) // R4
        else $error("write cycle broke on read-only select");

    property p_mask_all;
        (ignore == 32'hFFFFFFFF && select == 8'hFC && I_BUS.valid)
            |-> hit;
    endproperty
    a_mask_all: assert property (p_mask_all) // R11
        else $error("fully masked address failed to break");

    property p_addr_miss;
        (ignore == 32'h00000000 && I_BUS.addr != target) |-> !hit;
    endproperty
    a_addr_miss: assert property (p_addr_miss) // R15
        else $error("break on unmasked address mismatch");

    property p_fetch_flag;
        (hit && I_BUS.fetch && !I_BUS.dma)
            |=> O_BREAK_FETCH && evt_status[`EVT_FETCH];
    endproperty
    a_fetch_flag: assert property (p_fetch_flag) // R6
        else $error("fetch break flag not raised");

    property p_irq_level;
        (evt_status[`EVT_BREAK] && evt_mask[`EVT_BREAK]) |-> O_IRQ;
    endproperty
    a_irq_level: assert property (p_irq_level) // R5
        else $error("unmasked break without interrupt");

    property p_bvalid_hold;
        (O_BVALID && !I_BREADY) |=> O_BVALID && $stable(O_BRESP);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold)
        else $error("write response dropped early");

    property p_rvalid_hold;
        (O_RVALID && !I_RREADY) |=> O_RVALID && $stable(O_RDATA);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold)
        else $error("read data dropped early");

endmodule

// ### tb/bus_master_model.sv
// Behavioural processor and DMA bus cycle source
`timescale 1ns/1ps

module bus_master_model
    import break_unit_pkg::*;
(
    input  wire logic    i_clk,
    output bus_cycle_type o_bus
);
    initial o_bus = '0;

    // One cycle for one clock, then idle with valid low and every other field inverted
    task automatic issue(input bus_cycle_type c);
        @(posedge i_clk);
        o_bus <= c;
        @(posedge i_clk);
        o_bus <= bus_cycle_type'({1'b0, ~c[36:0]});
    endtask
endmodule

// ### tb/user_break_unit_bench.sv
// Self-checking bench for the user break unit
`timescale 1ns/1ps
`include "ubc_regs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    failures++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module user_break_unit_bench
    import break_unit_pkg::*;
();
    logic          clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic          awready, wready, bvalid, arready, rvalid, irq, brk;
    logic [31:0]   awaddr, wdata, araddr, rdata, rdv;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp, resp;
    bus_cycle_type bus;
    int            failures = 0, cmp_count = 0, cycles = 0;
    localparam logic [31:0] A = 32'h1234_5678;

    user_break_unit dut (.I_CLK(clk), .I_RST(rst), .I_BUS(bus),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
        .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
        .O_RVALID(rvalid), .I_RREADY(rready), .O_IRQ(irq),
        .O_BREAK_FETCH(brk));
    bus_master_model src (.i_clk(clk), .o_bus(bus));

    // 250 MHz clock
    always #2 clk = ~clk;

    function automatic logic [31:0] ba(input logic [27:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    function automatic bus_cycle_type mk(input logic d, f, w,
        input logic [1:0] s, input logic [31:0] a);
        return bus_cycle_type'({1'b1, d, f, w, s, a});
    endfunction

    // Write with address and data offered together
    task automatic wr(input logic [27:0] i, input logic [31:0] d,
                      input logic [3:0] s);
        logic pa, pw, ta, tw;
        @(posedge clk);
        awaddr <= ba(i);
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge clk);
            if (ta) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        // Ready raised a cycle late so the response must hold
        do @(negedge clk); while (!bvalid);
        @(posedge clk);
        bready <= 1'b1;
        @(negedge clk);
        resp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask

    // Read, data taken in the cycle that ends in the handshake
    task automatic rd(input logic [27:0] i);
        @(posedge clk);
        araddr <= ba(i);
        arvalid <= 1'b1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (!rvalid);
        @(posedge clk);
        rready <= 1'b1;
        @(negedge clk);
        rdv = rdata;
        resp = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task automatic cfg(input logic [31:0] a, m, input logic [7:0] s);
        wr(`IDX_ADDR_HIGH, a >> 16, 4'h3);
        wr(`IDX_ADDR_LOW, a, 4'h3);
        wr(`IDX_MASK_HIGH, m >> 16, 4'h3);
        wr(`IDX_MASK_LOW, m, 4'h3);
        wr(`IDX_CYCLE_SEL, {24'h0, s}, 4'h3);
    endtask

    // Clear status, send one cycle, check request and status bit
    task automatic hit(input bus_cycle_type c, input logic e);
        wr(`IDX_EVT_STATUS, 32'h3, 4'hF);
        src.issue(c);
        @(negedge clk);
        `CHK("irq", e, irq)
        rd(`IDX_EVT_STATUS);
        `CHK("hit", e, rdv[0])
    endtask

    task automatic t_reset;
        logic [27:0] ids [7] = '{`IDX_ADDR_HIGH, `IDX_ADDR_LOW,
            `IDX_MASK_HIGH, `IDX_MASK_LOW, `IDX_CYCLE_SEL,
            `IDX_EVT_STATUS, `IDX_EVT_MASK};
        for (int k = 0; k < 7; k++) begin
            rd(ids[k]);
            `CHK("reset value", 32'h0, rdv)
            `CHK("read resp", `RESP_OKAY, resp)
        end
        $display("test reset done");
    endtask

    task automatic t_regs;
        logic [27:0] ids [4] = '{`IDX_ADDR_HIGH, `IDX_ADDR_LOW,
            `IDX_MASK_HIGH, `IDX_MASK_LOW};
        for (int k = 0; k < 4; k++) begin
            wr(ids[k], 32'hFFFF_5AF0 + k, 4'hF);
            rd(ids[k]);
            `CHK("word write", 32'h5AF0 + k, rdv)
        end
        wr(`IDX_CYCLE_SEL, 32'hFFFF, 4'h3);
        rd(`IDX_CYCLE_SEL);
        `CHK("select bits", 32'h00FF, rdv)
        wr(`IDX_ADDR_HIGH, 32'h0011, 4'h1);
        wr(`IDX_ADDR_HIGH, 32'h2200, 4'h2);
        rd(`IDX_ADDR_HIGH);
        `CHK("byte write", 32'h2211, rdv)
        wr(`IDX_ADDR_LOW ^ 28'h0FFFE00, 32'hBEEF, 4'h3);
        rd(`IDX_ADDR_LOW);
        `CHK("alias", 32'hBEEF, rdv)
        wr(`IDX_ADDR_LOW ^ 28'h1000000, 32'h0, 4'h3);
        `CHK("upper bit resp", `RESP_SLVERR, resp)
        rd(28'h5FFFF9E);
        `CHK("unmapped data", 32'h0, rdv)
        `CHK("unmapped resp", `RESP_SLVERR, resp)
        $display("test regs done");
    endtask

    task automatic t_mask;
        cfg(A, 32'h0, 8'hFC);
        wr(`IDX_EVT_MASK, 32'h1, 4'h3);
        hit(mk(0, 0, 0, 2, A), 1'b1);
        hit(mk(0, 0, 0, 2, A ^ 32'h1), 1'b0);
        cfg(A, 32'h8000_0001, 8'hFC);
        hit(mk(0, 0, 0, 2, A ^ 32'h1), 1'b1);
        hit(mk(0, 0, 0, 2, A ^ 32'h8000_0000), 1'b1);
        hit(mk(0, 0, 0, 2, A ^ 32'h2), 1'b0);
        hit(mk(0, 0, 0, 2, A ^ 32'h0001_0000), 1'b0);
        cfg(A, 32'hFFFF_FFFF, 8'hFC);
        hit(mk(1, 1, 1, 1, ~A), 1'b1);
        $display("test mask done");
    endtask

    // Every code of each select field against matching cycles
    task automatic t_select;
        logic [1:0] v;
        cfg(A, 32'h0, 8'h00);
        hit(mk(0, 0, 0, 2, A), 1'b0);
        for (int k = 0; k < 4; k++) begin
            v = 2'(k);
            wr(`IDX_CYCLE_SEL, {24'h0, v, 6'h3C}, 4'h3);
            hit(mk(0, 0, 0, 0, A), v[0]);
            hit(mk(1, 0, 0, 0, A), v[1]);
            wr(`IDX_CYCLE_SEL, {24'h0, 2'b11, v, 4'hC}, 4'h3);
            hit(mk(0, 1, 0, 0, A), v[0]);
            hit(mk(0, 0, 0, 0, A), v[1]);
            wr(`IDX_CYCLE_SEL, {24'h0, 4'hF, v, 2'b00}, 4'h3);
            hit(mk(0, 0, 0, 1, A), v[0]);
            hit(mk(0, 0, 1, 1, A), v[1]);
            wr(`IDX_CYCLE_SEL, {24'h0, 6'h3F, v}, 4'h3);
            for (int s = 0; s < 3; s++)
                hit(mk(1, 0, 1, 2'(s), A), v == 0 || v == s + 1);
        end
        $display("test select done");
    endtask

    task automatic t_fetch;
        wr(`IDX_EVT_MASK, 32'h0, 4'h3);
        wr(`IDX_CYCLE_SEL, 32'hFC, 4'h3);
        wr(`IDX_EVT_STATUS, 32'h3, 4'h3);
        src.issue(mk(0, 1, 0, 2, A));
        @(negedge clk);
        `CHK("masked irq", 1'b0, irq)
        `CHK("fetch flag", 1'b1, brk)
        rd(`IDX_EVT_STATUS);
        `CHK("fetch status", 32'h3, rdv)
        wr(`IDX_EVT_MASK, 32'h2, 4'h3);
        @(negedge clk);
        `CHK("fetch irq", 1'b1, irq)
        wr(`IDX_EVT_STATUS, 32'h3, 4'h3);
        src.issue(mk(1, 0, 1, 0, A));
        @(negedge clk);
        `CHK("data flag", 1'b0, brk)
        `CHK("data irq", 1'b0, irq)
        rd(`IDX_EVT_STATUS);
        `CHK("data status", 32'h1, rdv)
        rd(`IDX_ADDR_HIGH);
        `CHK("kept high", 32'h1234, rdv)
        // Mid-run reset returns registers and status to zero
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`IDX_EVT_STATUS);
        `CHK("reset status", 32'h0, rdv)
        rd(`IDX_ADDR_HIGH);
        `CHK("reset high", 32'h0, rdv)
        $display("test fetch done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failures++;
            results;
        end
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr, wstrb} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_regs;
        t_mask;
        t_select;
        t_fetch;
        results;
    end
endmodule
